/* File: logic/wsc_sequencer.sv */
// Sample clock source selection and sequence table playback engine
// Operation
// R01 - Accept rate only 100 mS/s to 200 MS/s
// R02 - Reject segment length not multiple of four
// R03 - External source disables internal clock generator
// R04 - Reset selects internal; others then ignored
// R05 - External setting routes front-panel clock in
// R06 - Backplane line source, driver keeps below 62.5MHz
// R07 - Host loads segments before enabling table
// R08 - Entry holds step, segment, loops, advance, sync
// R09 - Links play in order without gaps
// R10 - Link may reference any stored segment
// R11 - Replay segment loop count times, 1..1048576
// R12 - Advance bit: proceed or wait trigger
// R13 - Sync bit drives output only in bit mode
// R14 - Normal sync high through whole sequence
// R15 - Ten tables; choosing one keeps mode
// R16 - Continuous restarts; triggered holds last sample
// R17 - Mixed: adv 0 auto, 1 repeats until trigger
// R18 - Reload loop counter on each link entry
`timescale 1ns/1ps
module wsc_sequencer
  import wsc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sample clock inputs (synchronous strobes)
  input wire logic int_clk_tick,
  input wire logic ext_clk_tick,
  input wire logic eclt0_clk_tick,
  // Configuration
  input wire logic [1:0] clk_source,
  input wire logic rate_wr,
  input wire logic [39:0] rate_msps,
  input wire logic [1:0] adv_mode,
  input wire logic cont_run,
  input wire logic sync_source,
  input wire logic seq_mode,
  input wire logic [TBL_W-1:0] active_table,
  input wire logic trigger,
  // Segment table writes
  input wire logic seg_wr,
  input wire logic [SEG_W-1:0] seg_wr_num,
  input wire logic [ADDR_W-1:0] seg_wr_base,
  input wire logic [LEN_W-1:0] seg_wr_len,
  // Link table writes
  input wire logic link_wr,
  input wire logic [TBL_W-1:0] link_wr_table,
  input wire logic [LINK_AW-1:0] link_wr_step,
  input wire logic [SEG_W-1:0] link_wr_seg,
  input wire logic [LOOP_W-1:0] link_wr_loops,
  input wire logic link_wr_adv,
  input wire logic link_wr_sync,
  input wire logic [LINK_AW-1:0] table_last_step,
  // Status and outputs
  output logic [39:0] rate_r,
  output logic rate_err_r,
  output logic len_err_r,
  output logic int_gen_en,
  output logic sample_clk_en,
  output logic [ADDR_W-1:0] sample_addr_r,
  output logic sample_valid_r,
  output logic sync_out_r,
  output logic sequence_span_marker_r,
  output logic busy_r
);
  // Reset synchroniser
  logic rst_s1_r, rst_s2_r;
  // Selected source register
  wsc_src_t src_r;
  // Segment table: base and length
  logic [ADDR_W-1:0] seg_base_r [2**SEG_W];
  logic [LEN_W-1:0] seg_len_r [2**SEG_W];
  // Link tables, flat index table*NUM_LINKS+step
  localparam int unsigned LT_DEPTH = NUM_TABLES * NUM_LINKS;
  logic [SEG_W-1:0] lk_seg_r [LT_DEPTH];
  logic [LOOP_W-1:0] lk_loops_r [LT_DEPTH];
  logic lk_adv_r [LT_DEPTH];
  logic lk_sync_r [LT_DEPTH];
  // Playback state
  typedef enum {ST_IDLE, ST_PLAY, ST_WAIT, ST_HOLD} wsc_st_t;
  wsc_st_t st_r;
  logic [LINK_AW-1:0] step_r;
  logic [LOOP_W-1:0] loop_r;
  logic [LEN_W-1:0] pos_r;
  logic [TBL_W-1:0] tbl_r;
  // Combinational helpers
  logic tick;
  logic [9:0] cur_idx;
  logic [9:0] nxt_idx;
  logic seg_end, link_end, last_step, adv_wait;

  // Two-flop reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Source register, defaults to internal
  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      src_r <= WSC_SRC_INT; // R04
    end else if (clk_source == 2'h1) begin
      src_r <= WSC_SRC_EXT; // R05
    end else if (clk_source == 2'h2) begin
      src_r <= WSC_SRC_ECLT0; // R06
    end else begin
      src_r <= WSC_SRC_INT;
    end
  end

  // Sample tick mux; unselected inputs ignored
  always_comb begin
    case (src_r)
      WSC_SRC_EXT: tick = ext_clk_tick; // R03 R05
      WSC_SRC_ECLT0: tick = eclt0_clk_tick; // R06
      default: tick = int_clk_tick; // R04
    endcase
  end
  // Internal generator off while an external source drives
  assign int_gen_en = (src_r == WSC_SRC_INT); // R03
  assign sample_clk_en = tick;

  // Rate register with range check
  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      rate_r <= RATE_MAX_MSPS;
      rate_err_r <= 1'b0;
    end else if (rate_wr) begin
      if (rate_msps < RATE_MIN_MSPS || rate_msps > RATE_MAX_MSPS) begin
        rate_err_r <= 1'b1; // R01
      end else begin
        rate_r <= rate_msps; // R01
        rate_err_r <= 1'b0;
      end
    end
  end

  // Segment table; lengths not a multiple of four, and zero, rejected
  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      len_err_r <= 1'b0;
    end else if (seg_wr) begin
      len_err_r <= ((seg_wr_len & {{(LEN_W-2){1'b0}}, LEN_ALIGN_MASK}) != '0) || (seg_wr_len == '0); // R02
    end
  end
  always_ff @(posedge core_clk) begin
    if (seg_wr && seg_wr_len[1:0] == 2'h0 && seg_wr_len != '0) begin
      seg_base_r[seg_wr_num] <= seg_wr_base; // R10
      seg_len_r[seg_wr_num] <= seg_wr_len; // R02
    end
  end

  // Link table store: four fields per entry, addressed by table and step
  always_ff @(posedge core_clk) begin
    if (link_wr && link_wr_table < TBL_W'(NUM_TABLES)) begin
      lk_seg_r[10'(link_wr_table) * 10'(NUM_LINKS) + 10'(link_wr_step)] <= link_wr_seg; // R08
      lk_loops_r[10'(link_wr_table) * 10'(NUM_LINKS) + 10'(link_wr_step)] <=
        (link_wr_loops > LOOP_MAX) ? LOOP_MAX : ((link_wr_loops < LOOP_MIN) ? LOOP_MIN : link_wr_loops); // R11
      lk_adv_r[10'(link_wr_table) * 10'(NUM_LINKS) + 10'(link_wr_step)] <= link_wr_adv; // R08
      lk_sync_r[10'(link_wr_table) * 10'(NUM_LINKS) + 10'(link_wr_step)] <= link_wr_sync; // R08
    end
  end

  // Decode current and following link
  assign cur_idx = 10'(tbl_r) * 10'(NUM_LINKS) + 10'(step_r);
  assign last_step = (step_r == table_last_step);
  assign nxt_idx = last_step ? 10'(tbl_r) * 10'(NUM_LINKS) : cur_idx + 10'h001;
  assign seg_end = (pos_r == seg_len_r[lk_seg_r[cur_idx]] - LEN_W'(4'h1));
  assign link_end = seg_end && (loop_r == LOOP_MIN);
  // Wait for a trigger before next link in triggered/step modes, and in mixed mode on links with the advance bit set
  always_comb begin
    case (wsc_adv_t'(adv_mode))
      WSC_ADV_TRIG: adv_wait = 1'b1;
      WSC_ADV_STEP: adv_wait = 1'b1;
      WSC_ADV_MIX: adv_wait = lk_adv_r[cur_idx]; // R17
      default: adv_wait = 1'b0;
    endcase
  end

  // Playback sequencer
  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      st_r <= ST_IDLE;
      step_r <= '0;
      loop_r <= LOOP_MIN;
      pos_r <= '0;
      tbl_r <= '0;
      sample_valid_r <= 1'b0;
      sample_addr_r <= '0;
    end else if (!seq_mode) begin
      st_r <= ST_IDLE; // R15
      sample_valid_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // Latch chosen table at sequence start
          tbl_r <= (active_table < TBL_W'(NUM_TABLES)) ? active_table : '0; // R15
          step_r <= '0;
          pos_r <= '0;
          loop_r <= lk_loops_r[(active_table < TBL_W'(NUM_TABLES)) ? 10'(active_table) * 10'(NUM_LINKS) : 10'h000]; // R18
          st_r <= ST_PLAY;
        end
        ST_PLAY: begin
          if (tick) begin
            sample_addr_r <= seg_base_r[lk_seg_r[cur_idx]] + pos_r; // R10
            sample_valid_r <= 1'b1;
            if (!seg_end) begin
              pos_r <= pos_r + LEN_W'(4'h1);
            end else if (wsc_adv_t'(adv_mode) == WSC_ADV_STEP || (adv_wait && wsc_adv_t'(adv_mode) == WSC_ADV_MIX)) begin
              // Repeat link until trigger
              pos_r <= '0;
              if (trigger) begin
                step_r <= last_step ? '0 : step_r + LINK_AW'(1'b1); // R17
                loop_r <= lk_loops_r[nxt_idx]; // R18
              end
            end else if (!link_end) begin
              pos_r <= '0;
              loop_r <= loop_r - LOOP_MIN; // R11
            end else if (last_step && !cont_run) begin
              st_r <= ST_HOLD; // R16
            end else if (adv_wait) begin
              st_r <= ST_WAIT; // R12
            end else begin
              // Seamless move to next link
              pos_r <= '0;
              step_r <= last_step ? '0 : step_r + LINK_AW'(1'b1); // R09 R16
              loop_r <= lk_loops_r[nxt_idx]; // R18
            end
          end
        end
        ST_WAIT: begin
          // Output holds last sample until trigger
          if (trigger) begin
            pos_r <= '0;
            step_r <= last_step ? '0 : step_r + LINK_AW'(1'b1); // R12
            loop_r <= lk_loops_r[nxt_idx]; // R18
            st_r <= ST_PLAY;
          end
        end
        default: begin
          // Stay on final sample
          st_r <= ST_HOLD; // R16
        end
      endcase
    end
  end

  // Sync output, span marker or per-link bit
  always_ff @(posedge core_clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      sequence_span_marker_r <= 1'b0;
      sync_out_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      sequence_span_marker_r <= (st_r == ST_PLAY || st_r == ST_WAIT); // R14
      busy_r <= (st_r != ST_IDLE);
      if (wsc_sync_t'(sync_source) == WSC_SYNC_BIT) begin
        sync_out_r <= (st_r == ST_PLAY) && lk_sync_r[cur_idx]; // R13
      end else begin
        sync_out_r <= (st_r == ST_PLAY || st_r == ST_WAIT); // R14
      end
    end
  end

  // Checks
  a_src_reset_int: assert property (@(posedge core_clk) $rose(rst_s2_r) |-> src_r == WSC_SRC_INT) // R04
    else $error("source not internal after reset");
  a_int_gen_off: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    src_r != WSC_SRC_INT |-> !int_gen_en) // R03
    else $error("internal generator on with external source");
  a_tick_ignore: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    src_r == WSC_SRC_INT && !int_clk_tick |-> !sample_clk_en) // R04
    else $error("foreign clock used while internal");
  a_eclt_route: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    src_r == WSC_SRC_ECLT0 |-> sample_clk_en == eclt0_clk_tick) // R06
    else $error("backplane clock not routed");
  a_ext_route: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    src_r == WSC_SRC_EXT |-> sample_clk_en == ext_clk_tick) // R05
    else $error("external clock not routed");
  a_rate_range: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    rate_wr && rate_msps > RATE_MAX_MSPS |=> rate_err_r && $stable(rate_r)) // R01
    else $error("out of range rate accepted");
  a_len_reject: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    seg_wr && seg_wr_len[1:0] != 2'h0 |=> len_err_r) // R02
    else $error("bad length not flagged");
  a_sync_normal: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    sync_source == 1'b0 |=> sync_out_r == sequence_span_marker_r) // R14
    else $error("normal sync differs from span marker");
  a_hold_stays: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    st_r == ST_HOLD && seq_mode |=> st_r == ST_HOLD && $stable(sample_addr_r)) // R16
    else $error("triggered run left final sample");
  a_seqmode_off: assert property (@(posedge core_clk) disable iff (!rst_s2_r)
    !seq_mode |=> st_r == ST_IDLE ##1 !busy_r) // R15
    else $error("sequence ran without sequenced mode");
  c_ext_src: cover property (@(posedge core_clk) src_r == WSC_SRC_EXT && tick);
  c_wait_trig: cover property (@(posedge core_clk) st_r == ST_WAIT ##1 st_r == ST_PLAY);
  c_hold: cover property (@(posedge core_clk) st_r == ST_HOLD);
  c_wrap: cover property (@(posedge core_clk) st_r == ST_PLAY && last_step && link_end && tick && cont_run);
endmodule : wsc_sequencer

/* File: common/wsc_pkg.sv */
// Package with constants and types for the waveform sequencer and clock select
package wsc_pkg;
  // Sample clock rate limits in millisamples per second
  localparam logic [39:0] RATE_MIN_MSPS = 40'h0000000064;      // 100 mS/s
  localparam logic [39:0] RATE_MAX_MSPS = 40'h2e90edd000;      // 200 MS/s
  // Backplane trigger line clock limit in kHz
  localparam int unsigned ECLT_MAX_KHZ = 62500;
  // Table geometry
  localparam int unsigned NUM_TABLES = 10;
  localparam int unsigned NUM_LINKS = 64;
  localparam int unsigned LINK_AW = 6;
  localparam int unsigned TBL_W = 4;
  localparam int unsigned SEG_W = 8;
  localparam int unsigned LOOP_W = 21;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned LEN_W = 24;
  localparam logic [LOOP_W-1:0] LOOP_MIN = 21'h000001;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 21'h100000;        // 1,048,576
  localparam logic [1:0] LEN_ALIGN_MASK = 2'h3;                 // Multiple of four
  // Sample clock source selection
  typedef enum logic [1:0] {WSC_SRC_INT, WSC_SRC_EXT, WSC_SRC_ECLT0} wsc_src_t;
  // Advance mode
  typedef enum logic [1:0] {WSC_ADV_AUTO, WSC_ADV_TRIG, WSC_ADV_STEP, WSC_ADV_MIX} wsc_adv_t;
  // Sync output source
  typedef enum logic {WSC_SYNC_NORMAL, WSC_SYNC_BIT} wsc_sync_t;
endpackage : wsc_pkg

/* File: testbench/wsc_src_model.sv */
// Model of the host-side sample clock sources feeding the sequencer
`timescale 1ns/1ps
module wsc_src_model (
  // Clock and tick enable
  input wire logic core_clk,
  input wire logic run,
  // Sample strobes, one per source
  output logic int_clk_tick,
  output logic ext_clk_tick,
  output logic eclt0_clk_tick
);
  // Free counter; distinct periods so a wrong source choice shows
  int cnt = 0;
  initial begin
    int_clk_tick = 1'b0;
    ext_clk_tick = 1'b0;
    eclt0_clk_tick = 1'b0;
  end
  // Strobes update on the edge and are settled before the bench looks, silent while stopped
  always @(posedge core_clk) begin
    cnt <= cnt + 1;
    int_clk_tick <= run && (cnt % 3 == 0);
    ext_clk_tick <= run && (cnt % 5 == 1);
    // Backplane strobe at most every second cycle, 62.5 MHz
    eclt0_clk_tick <= run && (cnt % 2 == 0);
  end
endmodule : wsc_src_model

/* File: testbench/waveform_sequencer_clocking_tb_top.sv */
// Self-checking bench for the sequencer and clock source select
`timescale 1ns/1ps
module waveform_sequencer_clocking_tb_top;
  import wsc_pkg::*;
  // Rate table row: value written, error and rate expected
  typedef struct {logic [39:0] r; logic e; logic [39:0] x;} wsc_row_t;
  logic core_clk = 1'b0, rst_n = 1'b0, run = 1'b0;
  logic it, et, bt;
  logic [1:0] clk_source = 2'h0, adv_mode = 2'h0;
  logic rate_wr = 1'b0, cont_run = 1'b1, sync_source = 1'b0, seq_mode = 1'b0, trigger = 1'b0;
  logic [39:0] rate_msps = 40'h0;
  logic [TBL_W-1:0] active_table = 4'h0, link_wr_table = 4'h0;
  logic seg_wr = 1'b0, link_wr = 1'b0, link_wr_adv = 1'b0, link_wr_sync = 1'b0;
  logic [SEG_W-1:0] seg_wr_num = 8'h0, link_wr_seg = 8'h0;
  logic [ADDR_W-1:0] seg_wr_base = 24'h0, exp_addr;
  logic [LEN_W-1:0] seg_wr_len = 24'h0;
  logic [LINK_AW-1:0] link_wr_step = 6'h0, table_last_step = 6'h1;
  logic [LOOP_W-1:0] link_wr_loops = 21'h0;
  logic [39:0] rate_r;
  logic rate_err_r, len_err_r, int_gen_en, sample_clk_en, sample_valid_r, sync_out_r, span_r, busy_r;
  logic [ADDR_W-1:0] sample_addr_r;
  int errors = 0, n_compared = 0, cycles = 0;
  wsc_row_t rows[4];
  // Clock and hang guard
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  wsc_src_model SRC (.core_clk(core_clk), .run(run), .int_clk_tick(it), .ext_clk_tick(et), .eclt0_clk_tick(bt));
  wsc_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n), .int_clk_tick(it), .ext_clk_tick(et),
    .eclt0_clk_tick(bt), .clk_source(clk_source), .rate_wr(rate_wr), .rate_msps(rate_msps),
    .adv_mode(adv_mode), .cont_run(cont_run), .sync_source(sync_source), .seq_mode(seq_mode),
    .active_table(active_table), .trigger(trigger), .seg_wr(seg_wr), .seg_wr_num(seg_wr_num),
    .seg_wr_base(seg_wr_base), .seg_wr_len(seg_wr_len), .link_wr(link_wr), .link_wr_table(link_wr_table),
    .link_wr_step(link_wr_step), .link_wr_seg(link_wr_seg), .link_wr_loops(link_wr_loops),
    .link_wr_adv(link_wr_adv), .link_wr_sync(link_wr_sync), .table_last_step(table_last_step),
    .rate_r(rate_r), .rate_err_r(rate_err_r), .len_err_r(len_err_r), .int_gen_en(int_gen_en),
    .sample_clk_en(sample_clk_en), .sample_addr_r(sample_addr_r), .sample_valid_r(sample_valid_r),
    .sync_out_r(sync_out_r), .sequence_span_marker_r(span_r), .busy_r(busy_r));
  // Compare one value and count it
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Move to just after a later rising edge
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  // Move to just after the next edge that consumes a sample tick
  task next_sample();
    for (int w = 0; w < 10 && !sample_clk_en; w++) step(1);
    step(1);
  endtask : next_sample
  // One-cycle segment definition strobe
  task wseg(input logic [7:0] num, input logic [23:0] base, input logic [23:0] len);
    seg_wr = 1'b1;
    seg_wr_num = num;
    seg_wr_base = base;
    seg_wr_len = len;
    step(1);
    seg_wr = 1'b0;
    step(1);
  endtask : wseg
  // One-cycle link definition strobe into table 0
  task wlink(input logic [5:0] stp, input logic [7:0] seg, input logic [20:0] loops);
    link_wr = 1'b1;
    link_wr_step = stp;
    link_wr_seg = seg;
    link_wr_loops = loops;
    step(1);
    link_wr = 1'b0;
    step(1);
  endtask : wlink
  // Verdict and end of run
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    rows[0] = '{40'h64, 1'b0, 40'h64};
    rows[1] = '{40'h63, 1'b1, 40'h64};
    rows[2] = '{RATE_MAX_MSPS, 1'b0, RATE_MAX_MSPS};
    rows[3] = '{RATE_MAX_MSPS + 40'h1, 1'b1, RATE_MAX_MSPS};
    step(10);
    rst_n = 1'b1;
    step(3);
    // Reset defaults: internal source, nothing playing
    chk(int_gen_en, 1'b1);
    chk(busy_r, 1'b0);
    $display("reset test done");
    // Rate limits, a refused value leaves the old rate
    rate_wr = 1'b1;
    foreach (rows[i]) begin
      rate_msps = rows[i].r;
      step(1);
      chk(rate_err_r, rows[i].e);
      chk(rate_r, rows[i].x);
    end
    rate_wr = 1'b0;
    $display("rate test done");
    // Source select: only the chosen strobe reaches the sample clock
    run = 1'b1;
    for (int s = 0; s < 3; s++) begin
      clk_source = s[1:0];
      step(2);
      chk(int_gen_en, s == 0);
      repeat (15) begin
        chk(sample_clk_en, s == 0 ? it : (s == 1 ? et : bt));
        step(1);
      end
    end
    clk_source = 2'h0;
    $display("source test done");
    // Lengths off the multiple of four, and zero, are refused
    wseg(8'h3, 24'h300, 24'h6);
    chk(len_err_r, 1'b1);
    wseg(8'h4, 24'h400, 24'h0);
    chk(len_err_r, 1'b1);
    wseg(8'h9, 24'h100, 24'h4);
    chk(len_err_r, 1'b0);
    wseg(8'h2, 24'h200, 24'h4);
    // Two links, out of segment number order, first looped twice
    run = 1'b0;
    wlink(6'h0, 8'h9, 21'h2);
    wlink(6'h1, 8'h2, 21'h1);
    active_table = 4'h0;
    step(3);
    chk(busy_r, 1'b0);
    seq_mode = 1'b1;
    step(3);
    run = 1'b1;
    // Every sample in order, no gaps, loop counts reloaded on wrap
    for (int k = 0; k < 30; k++) begin
      exp_addr = (k % 12 < 8 ? 24'h100 : 24'h200) + 24'(k % 4);
      next_sample();
      chk(sample_valid_r, 1'b1);
      chk(sample_addr_r, exp_addr);
      chk(sync_out_r, 1'b1);
      chk(span_r, 1'b1);
    end
    seq_mode = 1'b0;
    step(4);
    chk(sync_out_r, 1'b0);
    chk(span_r, 1'b0);
    chk(busy_r, 1'b0);
    $display("playback test done");
    // Triggered advance and run, sync taken from the link bit of link 1
    link_wr_sync = 1'b1;
    wlink(6'h1, 8'h2, 21'h1);
    link_wr_sync = 1'b0;
    adv_mode = 2'h1;
    cont_run = 1'b0;
    sync_source = 1'b1;
    seq_mode = 1'b1;
    step(1);
    for (int k = 0; k < 12; k++) begin
      if (k == 8) begin
        // Waiting between links: last sample stands until the trigger
        step(4);
        chk(sample_addr_r, 24'h103);
        chk(span_r, 1'b1);
        trigger = 1'b1;
        step(1);
        trigger = 1'b0;
      end
      next_sample();
      chk(sample_addr_r, (k < 8 ? 24'h100 : 24'h200) + 24'(k % 4));
      chk(sync_out_r, k >= 8);
    end
    step(4);
    chk(sample_addr_r, 24'h203);
    chk(sync_out_r, 1'b0);
    chk(span_r, 1'b0);
    chk(busy_r, 1'b1);
    // Mixed advance: link 0 repeats past its loop count until a trigger meets its end
    seq_mode = 1'b0;
    link_wr_adv = 1'b1;
    wlink(6'h0, 8'h9, 21'h2);
    link_wr_adv = 1'b0;
    adv_mode = 2'h3;
    cont_run = 1'b1;
    seq_mode = 1'b1;
    step(1);
    for (int k = 0; k < 20; k++) begin
      trigger = (k >= 12 && k < 16);
      next_sample();
      chk(sample_addr_r, (k < 16 ? 24'h100 : 24'h200) + 24'(k % 4));
    end
    trigger = 1'b0;
    $display("advance test done");
    report_and_stop();
  end
endmodule : waveform_sequencer_clocking_tb_top
